/* File: hw/dccs_sequencer.sv */
// conversion sequencer core of the dual channel temperature sensor
`timescale 1ns/1ps
// Notes on behaviour
// - a sequence starts on a host start request, on a one-shot request or on the free-running schedule.
// - once started, a sequence converts the remote and the local channel before ending, unless a standby request aborts it.
// - both channels are always measured, with no option to skip one.
// - the mux selects the remote diode first and then the local diode.
// - each channel is held selected for a 60 ms integration window.
// - at sequence end both results load into two temperature data registers.
// - new results are compared with the high and low alarm limits.
// - the busy flag is high while a conversion runs and clears when it ends.
// - during a conversion the data registers keep the previous complete results.
// - the alarm output is open drain, only pulling low or releasing.
// - a full conversion completes 125 ms after the start request.
// - a standby request aborts a running sequence without latching its data.
// - in standby the automatic schedule stops but one-shot requests still convert.
module dccs_sequencer
    import dccs_pkg::*;
#(
    parameter int INTEG_CNT = INTEG_CYCLES,
    parameter int SEQ_CNT   = SEQ_CYCLES,
    parameter int RATE_CNT  = RATE_CYCLES
) (
    input  wire logic              clk_sys,
    input  wire logic              rst,
    input  wire logic              clk_en,
    input  wire logic              start_req,
    input  wire logic              one_shot_req,
    input  wire logic              standby,
    input  wire logic [TEMP_W-1:0] adc_result,
    input  wire logic [TEMP_W-1:0] high_limit,
    input  wire logic [TEMP_W-1:0] low_limit,
    output logic                   busy,
    output logic                   sel_remote,
    output logic                   sel_local,
    output logic                   adc_integrate,
    output logic [TEMP_W-1:0]      temp_remote,
    output logic [TEMP_W-1:0]      temp_local,
    output logic                   remote_high,
    output logic                   remote_low,
    output logic                   local_high,
    output logic                   local_low,
    output logic                   alert_low_out,
    output logic                   alert_low_oe,
    output logic                   seq_done
);

    // ----------------------------------------
    // sequencing
    // ----------------------------------------
    dccs_state_t       state;
    logic [31:0]       phase_cnt;
    logic [31:0]       rate_cnt;
    logic              run_req;
    logic              rate_tick;

    assign rate_tick = (rate_cnt == 32'(RATE_CNT - 1));
    // one-shot honoured even in standby; auto schedule gated by standby
    assign run_req = start_req | one_shot_req | (rate_tick & ~standby);

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            rate_cnt <= 32'h0000_0000;
        end else if (clk_en) begin
            if (rate_tick || standby) begin
                rate_cnt <= 32'h0000_0000;
            end else begin
                rate_cnt <= rate_cnt + 32'h0000_0001;
            end
        end
    end

    // ----------------------------------------
    // standby edge, aborts a running sequence
    // ----------------------------------------
    logic standby_q;
    logic abort;

    // reset high so a part held in standby sees no false edge
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            standby_q <= 1'b1;
        end else if (clk_en) begin
            standby_q <= standby;
        end
    end

    // only a fresh standby request aborts; a one-shot in standby runs to its end
    assign abort = standby & ~standby_q;

    // remote then local then settle, total SEQ_CNT cycles
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            state     <= DCCS_IDLE;
            phase_cnt <= 32'h0000_0000;
        end else if (clk_en) begin
            case (state)
                DCCS_IDLE: begin
                    phase_cnt <= 32'h0000_0000;
                    if (run_req && !(standby && !one_shot_req)) begin
                        state <= DCCS_REMOTE;
                    end
                end
                DCCS_REMOTE: begin
                    phase_cnt <= phase_cnt + 32'h0000_0001;
                    if (abort) begin
                        state <= DCCS_IDLE;
                    end else if (phase_cnt == 32'(INTEG_CNT - 1)) begin
                        state <= DCCS_LOCAL;
                    end
                end
                DCCS_LOCAL: begin
                    phase_cnt <= phase_cnt + 32'h0000_0001;
                    if (abort) begin
                        state <= DCCS_IDLE;
                    end else if (phase_cnt == 32'(2 * INTEG_CNT - 1)) begin
                        state <= DCCS_SETTLE;
                    end
                end
                DCCS_SETTLE: begin
                    phase_cnt <= phase_cnt + 32'h0000_0001;
                    if (abort) begin
                        state <= DCCS_IDLE;
                    end else if (phase_cnt >= 32'(SEQ_CNT - 1)) begin
                        state <= DCCS_IDLE;
                    end
                end
                default: begin
                    state <= DCCS_IDLE;
                end
            endcase
        end
    end

    // ----------------------------------------
    // mux and status
    // ----------------------------------------
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            busy          <= 1'b0;
            sel_remote    <= 1'b0;
            sel_local     <= 1'b0;
            adc_integrate <= 1'b0;
        end else if (clk_en) begin
            busy          <= (state != DCCS_IDLE);
            sel_remote    <= (state == DCCS_REMOTE);
            sel_local     <= (state == DCCS_LOCAL);
            adc_integrate <= (state == DCCS_REMOTE) || (state == DCCS_LOCAL);
        end
    end

    // ----------------------------------------
    // results, held privately until sequence end
    // ----------------------------------------
    logic       last_remote;
    logic       last_local;
    logic       finish;
    logic       cmp_pending;
    logic [1:0] chan_last;

    assign last_remote = (state == DCCS_REMOTE) && (phase_cnt == 32'(INTEG_CNT - 1)) && !abort;
    assign last_local  = (state == DCCS_LOCAL) && (phase_cnt == 32'(2 * INTEG_CNT - 1))
                         && !abort;
    assign finish      = (state == DCCS_SETTLE) && (phase_cnt >= 32'(SEQ_CNT - 1)) && !abort;
    // index 0 is the remote channel, index 1 the local one
    assign chan_last   = {last_local, last_remote};

    // seq_done marks the one cycle in which the public registers move
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            seq_done <= 1'b0;
        end else if (clk_en) begin
            seq_done <= finish;
        end
    end

    // compare waits one cycle so it sees the registers the host reads
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            cmp_pending <= 1'b0;
        end else if (clk_en) begin
            cmp_pending <= finish;
        end
    end

    // ----------------------------------------
    // per channel capture, load and compare
    // ----------------------------------------
    generate
        for (genvar ch = 0; ch < 2; ch++) begin : g_chan
            logic [TEMP_W-1:0] hold;
            logic [TEMP_W-1:0] temp;
            logic              over_high;
            logic              under_low;

            // private capture at the last cycle of this channel's window
            always_ff @(posedge clk_sys or posedge rst) begin
                if (rst) begin
                    hold <= TEMP_RST;
                end else if (clk_en) begin
                    if (chan_last[ch]) begin
                        hold <= adc_result;
                    end
                end
            end

            // public register moves only at finish, so reads never see a half update
            always_ff @(posedge clk_sys or posedge rst) begin
                if (rst) begin
                    temp <= TEMP_RST;
                end else if (clk_en) begin
                    if (finish) begin
                        temp <= hold;
                    end
                end
            end

            // signed two's complement, strict on both limits
            always_ff @(posedge clk_sys or posedge rst) begin
                if (rst) begin
                    over_high <= 1'b0;
                    under_low <= 1'b0;
                end else if (clk_en) begin
                    if (cmp_pending) begin
                        over_high <= $signed(temp) > $signed(high_limit);
                        under_low <= $signed(temp) < $signed(low_limit);
                    end
                end
            end
        end
    endgenerate

    // outputs are the flip-flops of the channel blocks, no logic between
    assign temp_remote = g_chan[0].temp;
    assign temp_local  = g_chan[1].temp;
    assign remote_high = g_chan[0].over_high;
    assign remote_low  = g_chan[0].under_low;
    assign local_high  = g_chan[1].over_high;
    assign local_low   = g_chan[1].under_low;

    // open drain: drive low only, never high
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            alert_low_out <= 1'b0;
            alert_low_oe  <= 1'b0;
        end else if (clk_en) begin
            alert_low_out <= 1'b0;
            alert_low_oe  <= remote_high | remote_low | local_high | local_low;
        end
    end

endmodule : dccs_sequencer

/* File: shared/dccs_pkg.sv */
// package for the dual channel conversion sequencer
package dccs_pkg;

    localparam int  CLK_HZ          = 200_000_000;
    localparam int  INTEG_MS        = 60;
    localparam int  INTEG_CYCLES    = INTEG_MS * (CLK_HZ / 1000);
    localparam int  SEQ_MS          = 125;
    localparam int  SEQ_CYCLES      = SEQ_MS * (CLK_HZ / 1000);
    localparam int  RATE_MS         = 1000;
    localparam int  RATE_CYCLES     = RATE_MS * (CLK_HZ / 1000);
    localparam int  TEMP_W          = 12;
    localparam logic [11:0] TEMP_RST     = 12'h000;
    localparam logic [11:0] HIGH_LIM_RST = 12'h550;
    localparam logic [11:0] LOW_LIM_RST  = 12'h800;

    typedef enum logic [1:0] {
        DCCS_IDLE,
        DCCS_REMOTE,
        DCCS_LOCAL,
        DCCS_SETTLE
    } dccs_state_t;

endpackage : dccs_pkg

/* File: tb/dccs_props.sv */
// assertion checker for the conversion sequencer
`timescale 1ns/1ps
module dccs_props
    import dccs_pkg::*;
#(
    parameter int INTEG_CNT = 8,
    parameter int SEQ_CNT   = 20
) (
    input wire logic              clk_sys,
    input wire logic              rst,
    input wire logic              start_req,
    input wire logic              standby,
    input wire logic [TEMP_W-1:0] high_limit,
    input wire logic [TEMP_W-1:0] low_limit,
    input wire logic              busy,
    input wire logic              sel_remote,
    input wire logic              sel_local,
    input wire logic              adc_integrate,
    input wire logic [TEMP_W-1:0] temp_remote,
    input wire logic [TEMP_W-1:0] temp_local,
    input wire logic              remote_high,
    input wire logic              remote_low,
    input wire logic              local_high,
    input wire logic              local_low,
    input wire logic              alert_low_out,
    input wire logic              alert_low_oe,
    input wire logic              seq_done
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    int rcnt;
    int bcnt;
    // run lengths of the remote select and of busy
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            rcnt <= 0;
            bcnt <= 0;
        end else begin
            rcnt <= sel_remote ? rcnt + 1 : 0;
            bcnt <= busy ? bcnt + 1 : 0;
        end
    end
    sequence s_take;
        start_req && !standby && !busy && !sel_remote && !sel_local;
    endsequence
    sequence s_cmp;
        seq_done ##3 1'b1;
    endsequence
    AST_TAKE: assert property (s_take |-> ##2 busy) else $error("start not taken");
    AST_REMOTE_FIRST: assert property ($rose(adc_integrate) |-> sel_remote && !sel_local)
        else $error("remote not first");
    AST_REMOTE_WIN: assert property ($rose(sel_local) |-> rcnt == INTEG_CNT)
        else $error("remote window length wrong");
    AST_SEQ_TIME: assert property (seq_done |-> bcnt >= SEQ_CNT - 4 && bcnt <= SEQ_CNT)
        else $error("sequence length wrong");
    AST_HOLD: assert property ($changed(temp_remote) || $changed(temp_local) |-> seq_done)
        else $error("results changed outside sequence end");
    AST_BUSY_END: assert property (seq_done |-> busy ##[1:2] !busy)
        else $error("busy not cleared");
    AST_CMP: assert property (s_cmp |-> remote_high == ($signed(temp_remote) > $signed(high_limit))
        && remote_low == ($signed(temp_remote) < $signed(low_limit))
        && local_high == ($signed(temp_local) > $signed(high_limit))
        && local_low == ($signed(temp_local) < $signed(low_limit)))
        else $error("alarm compare wrong");
    AST_ALERT_OD: assert property (!alert_low_out) else $error("alert driven high");
    AST_ALERT_ANY: assert property (s_cmp ##1 1'b1 |->
        alert_low_oe == (remote_high || remote_low || local_high || local_low))
        else $error("alert enable wrong");
endmodule : dccs_props
bind dccs_sequencer dccs_props #(.INTEG_CNT(INTEG_CNT), .SEQ_CNT(SEQ_CNT)) u_props (.*);

/* File: tb/dccs_far_model.sv */
// far side model: converter input values and pulled-up alert line
`timescale 1ns/1ps
module dccs_far_model
    import dccs_pkg::*;
(
    input  wire logic [TEMP_W-1:0] rem_val,
    input  wire logic [TEMP_W-1:0] loc_val,
    input  wire logic              sel_remote,
    input  wire logic              sel_local,
    input  wire logic              alert_low_out,
    input  wire logic              alert_low_oe,
    output logic      [TEMP_W-1:0] adc_result,
    output logic                   alert_low_line
);
    // nothing selected shows flipped data so a stale sample cannot pass
    assign adc_result = sel_remote ? rem_val : (sel_local ? loc_val : ~loc_val);
    // released line floats up through the board pull-up
    assign alert_low_line = alert_low_oe ? alert_low_out : 1'b1;
endmodule : dccs_far_model

/* File: tb/tb_dccs_sequencer.sv */
// testbench for the conversion sequencer
`timescale 1ns/1ps
module tb_dccs_sequencer;
    import dccs_pkg::*;
    logic              clk_sys = 0, rst = 1, clk_en = 1, start_req = 0, one_shot_req = 0;
    logic              standby = 1, busy, sel_remote, sel_local, adc_integrate, seq_done;
    logic              remote_high, remote_low, local_high, local_low;
    logic              alert_low_out, alert_low_oe, alert_low_line;
    logic [TEMP_W-1:0] rem_val = 0, loc_val = 0, high_limit = 0, low_limit = 0;
    logic [TEMP_W-1:0] adc_result, temp_remote, temp_local;
    logic [23:0]       notes[$];
    logic [23:0]       last = 0;
    int                fails = 0, compares = 0, dones = 0;
    always #2.5 clk_sys = ~clk_sys;
    dccs_sequencer #(.INTEG_CNT(8), .SEQ_CNT(20), .RATE_CNT(50)) dut (.*);
    dccs_far_model u_far (.*);
    task automatic check(input logic [23:0] seen, input logic [23:0] want);
        compares++;
        if (seen !== want) begin
            fails++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, want);
        end
    endtask : check
    task automatic final_report;
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : final_report
    function automatic logic [3:0] alarms(input logic [23:0] t);
        return {$signed(t[23:12]) > $signed(high_limit), $signed(t[23:12]) < $signed(low_limit),
                $signed(t[11:0]) > $signed(high_limit), $signed(t[11:0]) < $signed(low_limit)};
    endfunction : alarms
    // results checked against the oldest note; an extra sequence finds none
    always @(posedge clk_sys) begin
        #1;
        if (seq_done === 1'b1) begin
            dones++;
            last = notes.size() ? notes.pop_front() : ~{temp_remote, temp_local};
            check({temp_remote, temp_local}, last);
            repeat (3) @(posedge clk_sys);
            #1;
            check({remote_high, remote_low, local_high, local_low}, alarms(last));
            @(posedge clk_sys);
            #1;
            check(alert_low_line, ~|alarms(last));
        end
    end
    // kind 0 waits for the auto schedule, 1 start, 2 one-shot
    task automatic run(input int kind);
        int d;
        d = dones;
        rem_val <= TEMP_W'($urandom);
        loc_val <= TEMP_W'($urandom);
        @(posedge clk_sys);
        notes.push_back({rem_val, loc_val});
        start_req <= (kind == 1);
        one_shot_req <= (kind == 2);
        @(posedge clk_sys);
        start_req <= 0;
        one_shot_req <= 0;
        repeat (5) @(posedge clk_sys);
        start_req <= (kind != 0);
        @(posedge clk_sys);
        start_req <= 0;
        repeat (100) if (dones == d) @(posedge clk_sys);
        check(dones, d + 1);
    endtask : run
    initial begin
        #25000;
        fails++;
        final_report();
    end
    initial begin
        void'($urandom(32'hE34CCCE5));
        high_limit <= TEMP_W'($urandom);
        low_limit <= TEMP_W'($urandom);
        repeat (3) @(posedge clk_sys);
        rst <= 0;
        @(posedge clk_sys);
        #1;
        check({temp_remote, temp_local}, 24'h0);
        run(2);
        run(2);
        standby <= 0;
        run(1);
        run(0);
        start_req <= 1;
        @(posedge clk_sys);
        start_req <= 0;
        repeat (12) @(posedge clk_sys);
        standby <= 1;
        repeat (40) @(posedge clk_sys);
        check({temp_remote, temp_local}, last);
        final_report();
    end
endmodule : tb_dccs_sequencer
